/* rtl/itb_top.sv */
// interrupt controller with two time bases, wake-up and return handling
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module itb_top (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic [3:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    input wire logic I_LOW_VOLTAGE,
    input wire logic I_NVM_WRITE_DONE,
    input wire logic I_SERIAL_EVENT,
    input wire logic I_SUB_CLK,
    input wire logic I_STACK_FULL,
    input wire logic I_CALL_TAKEN,
    input wire logic I_RETURN_FROM_INTERRUPT,
    input wire logic I_PLAIN_RETURN,
    output logic O_CALL_REQ,
    output logic [2:0] O_CALL_VECTOR,
    output logic O_WAKE
);
    itb_tick_if tb0_if ();
    itb_tick_if tb1_if ();

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers: three stages, change accepted when 2 and 3 agree
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] pin_state;
    logic [3:0] pin_rise;
    logic [3:0] raw_pins;
    assign raw_pins = {I_SUB_CLK, I_SERIAL_EVENT, I_NVM_WRITE_DONE,
                       I_LOW_VOLTAGE};

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            pin_state <= '0;
        end else begin
            sync1 <= raw_pins;
            sync2 <= sync1;
            sync3 <= sync2;
            for (int i = 0; i < 4; i++) begin
                if (sync2[i] == sync3[i]) begin
                    pin_state[i] <= sync3[i];
                end
            end
        end
    end

    // edge of the filtered levels; sources report by rising edges
    logic [3:0] pin_prev;
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            pin_prev <= '0;
        end else begin
            pin_prev <= pin_state;
        end
    end
    assign pin_rise = pin_state & ~pin_prev;

    ////////////////////////////////////////////////////////////////////
    // registers
    logic [1:0] prescaler_source_select;
    logic timebase_zero_run;
    logic [2:0] timebase_zero_period_code;
    logic timebase_one_run;
    logic [2:0] timebase_one_period_code;
    logic global_irq_enable;
    logic low_voltage_irq_enable;
    logic nvm_write_irq_enable;
    logic timebase_zero_irq_enable;
    logic timebase_one_irq_enable;
    logic serial_module_irq_enable;
    logic [itb_pkg::NUM_SRC-1:0] flags;
    logic [itb_pkg::NUM_SRC-1:0] enables;
    logic wr_irq_flags;
    logic wr_aux_flags;
    assign wr_irq_flags = I_WR && (I_ADDR == itb_pkg::ADDR_IRQ_FLAGS);
    assign wr_aux_flags = I_WR && (I_ADDR == itb_pkg::ADDR_IRQ_ENABLES);

    // configuration writes
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            prescaler_source_select <= '0;
            timebase_zero_run <= 1'b0;
            timebase_zero_period_code <= '0;
            timebase_one_run <= 1'b0;
            timebase_one_period_code <= '0;
            timebase_zero_irq_enable <= 1'b0;
            timebase_one_irq_enable <= 1'b0;
            serial_module_irq_enable <= 1'b0;
            low_voltage_irq_enable <= 1'b0;
            nvm_write_irq_enable <= 1'b0;
        end else if (I_WR) begin
            unique case (I_ADDR)
                itb_pkg::ADDR_PSC: begin
                    prescaler_source_select <= I_WDATA[itb_pkg::SEL_W-1:0];
                end
                itb_pkg::ADDR_TB0: begin
                    timebase_zero_run <= I_WDATA[itb_pkg::RUN_BIT];
                    timebase_zero_period_code <=
                        I_WDATA[itb_pkg::CODE_LSB +: itb_pkg::CODE_W];
                end
                itb_pkg::ADDR_TB1: begin
                    timebase_one_run <= I_WDATA[itb_pkg::RUN_BIT];
                    timebase_one_period_code <=
                        I_WDATA[itb_pkg::CODE_LSB +: itb_pkg::CODE_W];
                end
                itb_pkg::ADDR_IRQ_FLAGS: begin
                    serial_module_irq_enable <=
                        I_WDATA[itb_pkg::POS_SERIAL_EN];
                    timebase_one_irq_enable <= I_WDATA[itb_pkg::POS_TB1_EN];
                    timebase_zero_irq_enable <= I_WDATA[itb_pkg::POS_TB0_EN];
                end
                itb_pkg::ADDR_IRQ_ENABLES: begin
                    low_voltage_irq_enable <= I_WDATA[itb_pkg::POS_LV];
                    nvm_write_irq_enable <= I_WDATA[itb_pkg::POS_NVM];
                end
                default: begin
                end
            endcase
        end
    end

    assign enables = {serial_module_irq_enable, timebase_one_irq_enable,
                      timebase_zero_irq_enable, nvm_write_irq_enable,
                      low_voltage_irq_enable};

    ////////////////////////////////////////////////////////////////////
    // prescaler: shared tick for both dividers
    logic [itb_pkg::DIV4_W-1:0] div4;
    logic psc_tick;
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            div4 <= '0;
        end else begin
            div4 <= div4 + 1'b1;
        end
    end
    // subsidiary clock is slow, so its synchronised rising edge is the tick
    always_comb begin
        if (prescaler_source_select == itb_pkg::SEL_SYS) begin
            psc_tick = 1'b1;
        end else if (prescaler_source_select == itb_pkg::SEL_SYS_DIV4) begin
            psc_tick = (div4 == '1);
        end else begin
            psc_tick = pin_rise[3];
        end
    end

    assign tb0_if.tick = psc_tick;
    assign tb0_if.run = timebase_zero_run;
    assign tb0_if.code = timebase_zero_period_code;
    assign tb1_if.tick = psc_tick;
    assign tb1_if.run = timebase_one_run;
    assign tb1_if.code = timebase_one_period_code;

    itb_timebase u_tb0 (
        .i_clk(I_CLK),
        .i_rst_n(I_RST_N),
        .tb(tb0_if.divider)
    );
    itb_timebase u_tb1 (
        .i_clk(I_CLK),
        .i_rst_n(I_RST_N),
        .tb(tb1_if.divider)
    );

    ////////////////////////////////////////////////////////////////////
    // request flags: set beats clear, service clears only its own flag
    logic [itb_pkg::NUM_SRC-1:0] set_ev;
    logic [itb_pkg::NUM_SRC-1:0] clr_ev;
    logic [itb_pkg::NUM_SRC-1:0] sw_wr_mask;
    logic [itb_pkg::NUM_SRC-1:0] sw_wr_val;
    logic [2:0] pending_src;
    logic serviced;
    always_comb begin
        set_ev = '0;
        set_ev[itb_pkg::SRC_LV] = pin_rise[0];
        set_ev[itb_pkg::SRC_NVM] = pin_rise[1];
        set_ev[itb_pkg::SRC_TB0] = tb0_if.overflow;
        set_ev[itb_pkg::SRC_TB1] = tb1_if.overflow;
        set_ev[itb_pkg::SRC_SERIAL] = pin_rise[2];
        sw_wr_mask = '0;
        sw_wr_val = '0;
        if (wr_irq_flags) begin
            sw_wr_mask[itb_pkg::SRC_TB0] = 1'b1;
            sw_wr_mask[itb_pkg::SRC_TB1] = 1'b1;
            sw_wr_mask[itb_pkg::SRC_SERIAL] = 1'b1;
            sw_wr_val[itb_pkg::SRC_TB0] = I_WDATA[itb_pkg::POS_TB0_FLAG];
            sw_wr_val[itb_pkg::SRC_TB1] = I_WDATA[itb_pkg::POS_TB1_FLAG];
            sw_wr_val[itb_pkg::SRC_SERIAL] =
                I_WDATA[itb_pkg::POS_SERIAL_FLAG];
        end
        if (wr_aux_flags) begin
            sw_wr_mask[itb_pkg::SRC_LV] = 1'b1;
            sw_wr_mask[itb_pkg::SRC_NVM] = 1'b1;
            sw_wr_val[itb_pkg::SRC_LV] = I_WDATA[itb_pkg::POS_LV_FLAG];
            sw_wr_val[itb_pkg::SRC_NVM] = I_WDATA[itb_pkg::POS_NVM_FLAG];
        end
        clr_ev = '0;
        if (serviced) begin
            clr_ev[pending_src] = 1'b1;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            flags <= '0;
        end else begin
            for (int i = 0; i < itb_pkg::NUM_SRC; i++) begin
                if (set_ev[i]) begin
                    flags[i] <= 1'b1;
                end else if (sw_wr_mask[i]) begin
                    flags[i] <= sw_wr_val[i];
                end else if (clr_ev[i]) begin
                    flags[i] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // arbitration and core handshake
    logic [itb_pkg::NUM_SRC-1:0] ready_src;
    logic any_ready;
    logic [2:0] next_src;
    itb_pkg::itb_state_t state;
    assign ready_src = flags & enables;
    assign any_ready = |ready_src;
    always_comb begin
        next_src = '0;
        for (int i = itb_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (ready_src[i]) begin
                next_src = 3'(i);
            end
        end
    end
    assign serviced = (state == itb_pkg::ITB_CALL) && I_CALL_TAKEN;

    // request held until the core takes the call; only pc goes on stack
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state <= itb_pkg::ITB_IDLE;
            pending_src <= '0;
            O_CALL_REQ <= 1'b0;
            O_CALL_VECTOR <= '0;
        end else begin
            unique case (state)
                itb_pkg::ITB_IDLE: begin
                    if (global_irq_enable && any_ready
                        && !I_STACK_FULL) begin
                        state <= itb_pkg::ITB_CALL;
                        pending_src <= next_src;
                        O_CALL_REQ <= 1'b1;
                        O_CALL_VECTOR <= next_src;
                    end
                end
                itb_pkg::ITB_CALL: begin
                    if (I_CALL_TAKEN) begin
                        state <= itb_pkg::ITB_IDLE;
                        O_CALL_REQ <= 1'b0;
                    end
                end
                default: begin
                    state <= itb_pkg::ITB_IDLE;
                    O_CALL_REQ <= 1'b0;
                end
            endcase
        end
    end

    // global enable: service clears, return from interrupt sets
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            global_irq_enable <= 1'b0;
        end else if (serviced) begin
            global_irq_enable <= 1'b0;
        end else if (I_RETURN_FROM_INTERRUPT) begin
            global_irq_enable <= 1'b1;
        end else if (I_WR && I_ADDR == itb_pkg::ADDR_CORE_CTRL) begin
            global_irq_enable <= I_WDATA[itb_pkg::POS_GLOBAL_EN];
        end
        // plain return leaves it untouched
    end

    // wake pulse on any flag rising, enables not consulted
    logic [itb_pkg::NUM_SRC-1:0] flags_prev;
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            flags_prev <= '0;
            O_WAKE <= 1'b0;
        end else begin
            flags_prev <= flags;
            O_WAKE <= |(flags & ~flags_prev);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read port, data in the cycle after the strobe
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_RDATA <= itb_pkg::RESET_BYTE;
        end else if (I_RD) begin
            O_RDATA <= itb_pkg::RESET_BYTE;
            unique case (I_ADDR)
                itb_pkg::ADDR_PSC: begin
                    O_RDATA <= {6'h00, prescaler_source_select};
                end
                itb_pkg::ADDR_TB0: begin
                    O_RDATA <= {timebase_zero_run, 4'h0,
                                timebase_zero_period_code};
                end
                itb_pkg::ADDR_TB1: begin
                    O_RDATA <= {timebase_one_run, 4'h0,
                                timebase_one_period_code};
                end
                itb_pkg::ADDR_IRQ_FLAGS: begin
                    O_RDATA <= {1'b0, flags[itb_pkg::SRC_SERIAL],
                                flags[itb_pkg::SRC_TB1],
                                flags[itb_pkg::SRC_TB0], 1'b0,
                                serial_module_irq_enable,
                                timebase_one_irq_enable,
                                timebase_zero_irq_enable};
                end
                itb_pkg::ADDR_IRQ_ENABLES: begin
                    O_RDATA <= {2'h0, flags[itb_pkg::SRC_NVM],
                                flags[itb_pkg::SRC_LV], 2'h0,
                                nvm_write_irq_enable,
                                low_voltage_irq_enable};
                end
                itb_pkg::ADDR_CORE_CTRL: begin
                    O_RDATA <= {7'h00, global_irq_enable};
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    sequence call_raised;
        !O_CALL_REQ ##1 O_CALL_REQ;
    endsequence
    gated_call_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        call_raised |-> $past(global_irq_enable) && !$past(I_STACK_FULL))
        else $error("call raised without enable or free stack");
    service_clear_a: assert property (@(posedge I_CLK)
        disable iff (!I_RST_N) serviced |=> !global_irq_enable)
        else $error("global enable not cleared on service");
    return_from_interrupt_set_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        I_RETURN_FROM_INTERRUPT && !serviced |=> global_irq_enable)
        else $error("return from interrupt left enable low");
    ret_keep_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        I_PLAIN_RETURN && !I_RETURN_FROM_INTERRUPT && !serviced && !I_WR
        |=> global_irq_enable == $past(global_irq_enable))
        else $error("plain return changed global enable");
    flag_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        flags[itb_pkg::SRC_LV] && !clr_ev[itb_pkg::SRC_LV]
        && !sw_wr_mask[itb_pkg::SRC_LV] |=> flags[itb_pkg::SRC_LV])
        else $error("low voltage flag dropped");
    lv_set_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        pin_rise[0] |=> flags[itb_pkg::SRC_LV])
        else $error("low voltage flag not set");
    wake_rise_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        $rose(flags[itb_pkg::SRC_TB0]) |=> O_WAKE)
        else $error("flag rise did not wake");
    tb_flag_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        tb1_if.overflow |=> flags[itb_pkg::SRC_TB1])
        else $error("time base 1 overflow lost");
    full_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        !O_CALL_REQ && I_STACK_FULL |=> !O_CALL_REQ)
        else $error("call raised with stack full");
endmodule

/* rtl/itb_pkg.sv */
// package of constants and types for the interrupt and time base block
package itb_pkg;
    // register addresses (chosen, 4-bit port address)
    localparam logic [3:0] ADDR_PSC = 4'h0;
    localparam logic [3:0] ADDR_TB0 = 4'h1;
    localparam logic [3:0] ADDR_TB1 = 4'h2;
    localparam logic [3:0] ADDR_IRQ_FLAGS = 4'h3;
    localparam logic [3:0] ADDR_IRQ_ENABLES = 4'h4;
    localparam logic [3:0] ADDR_CORE_CTRL = 4'h5;
    // field positions
    localparam int RUN_BIT = 7;
    localparam int CODE_LSB = 0;
    localparam int CODE_W = 3;
    localparam int SEL_W = 2;
    // interrupt control register bit positions
    localparam int POS_SERIAL_FLAG = 6;
    localparam int POS_TB1_FLAG = 5;
    localparam int POS_TB0_FLAG = 4;
    localparam int POS_SERIAL_EN = 2;
    localparam int POS_TB1_EN = 1;
    localparam int POS_TB0_EN = 0;
    // second flag register: low voltage and nvm
    localparam int POS_LV = 0;
    localparam int POS_NVM = 1;
    // aux register flag bits, sitting above the enables
    localparam int POS_LV_FLAG = 4;
    localparam int POS_NVM_FLAG = 5;
    // core control: global enable bit
    localparam int POS_GLOBAL_EN = 0;
    // source indices in fixed priority order, lowest index wins
    localparam int NUM_SRC = 5;
    localparam int SRC_LV = 0;
    localparam int SRC_NVM = 1;
    localparam int SRC_TB0 = 2;
    localparam int SRC_TB1 = 3;
    localparam int SRC_SERIAL = 4;
    // prescaler source codes
    localparam logic [1:0] SEL_SYS = 2'h0;
    localparam logic [1:0] SEL_SYS_DIV4 = 2'h1;
    localparam int DIV4_W = 2;
    // time base divider: 2^(8+code), longest 2^15
    localparam int TB_BASE_EXP = 8;
    localparam int TB_CNT_W = 15;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    typedef enum logic [1:0] {ITB_IDLE, ITB_CALL} itb_state_t;
endpackage

/* rtl/itb_tick_if.sv */
// interface carrying prescaler tick and one divider's setup and overflow
`timescale 1ns/1ps
interface itb_tick_if;
    logic tick;
    logic run;
    logic [2:0] code;
    logic overflow;
    modport ctrl (output tick, output run, output code, input overflow);
    modport divider (input tick, input run, input code, output overflow);
endinterface

/* rtl/itb_timebase.sv */
// one time base divider: overflow pulse every 2^(8+code) prescaler ticks
`timescale 1ns/1ps
module itb_timebase (
    input wire logic i_clk,
    input wire logic i_rst_n,
    itb_tick_if.divider tb
);
    logic [itb_pkg::TB_CNT_W-1:0] count;
    logic [itb_pkg::TB_CNT_W-1:0] limit;
    logic overflow;

    // terminal count from the period code
    always_comb begin
        limit = itb_pkg::TB_CNT_W'((32'h1 << (itb_pkg::TB_BASE_EXP
            + int'(tb.code))) - 32'h1);
    end

    // counter held clear while stopped so each start is a full period
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count <= '0;
            overflow <= 1'b0;
        end else if (!tb.run) begin
            count <= '0;
            overflow <= 1'b0;
        end else if (tb.tick) begin
            overflow <= (count >= limit);
            count <= (count >= limit) ? '0 : count + 1'b1;
        end else begin
            overflow <= 1'b0;
        end
    end
    assign tb.overflow = overflow;
endmodule

/* testbench/itb_core_model.sv */
// behavioural core: takes vector calls and counts return stack entries
`timescale 1ns/1ps
module itb_core_model #(parameter int DEPTH = 2) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_call_req,
    input wire logic i_pop,
    input wire logic i_slow,
    output logic o_call_taken,
    output logic o_stack_full
);
    logic [3:0] wait_cnt;
    logic [3:0] depth;

    ////////////////////////////////////////////////////////////////////////
    // accept after one or five cycles; only the return address is pushed
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wait_cnt <= 4'h0;
            o_call_taken <= 1'b0;
        end else if (i_call_req && !o_call_taken) begin
            wait_cnt <= wait_cnt + 4'h1;
            o_call_taken <= (wait_cnt >= (i_slow ? 4'h4 : 4'h0));
        end else begin
            wait_cnt <= 4'h0;
            o_call_taken <= 1'b0;
        end
    end

    // no nested subroutine calls: depth rises only on vector calls and falls on every return
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            depth <= 4'h0;
        end else begin
            depth <= depth + {3'h0, o_call_taken} - {3'h0, i_pop};
        end
    end
    assign o_stack_full = (depth == 4'(DEPTH));
endmodule

/* testbench/itb_top_tb.sv */
// self-checking bench for the interrupt and time base block
`timescale 1ns/1ps
module itb_top_tb;
    logic clk, rst_n, wr, rd, lv, nvm, ser, sub_clk, ret_irq, ret_plain;
    logic slow, call_req, wake, taken, full;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    logic [2:0] vec;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;
    int k;

    itb_top dut (.I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
        .I_LOW_VOLTAGE(lv), .I_NVM_WRITE_DONE(nvm), .I_SERIAL_EVENT(ser),
        .I_SUB_CLK(sub_clk), .I_STACK_FULL(full), .I_CALL_TAKEN(taken),
        .I_RETURN_FROM_INTERRUPT(ret_irq), .I_PLAIN_RETURN(ret_plain),
        .O_CALL_REQ(call_req), .O_CALL_VECTOR(vec), .O_WAKE(wake));
    itb_core_model #(.DEPTH(2)) core (.i_clk(clk), .i_rst_n(rst_n),
        .i_call_req(call_req), .i_pop(ret_irq | ret_plain),
        .i_slow(slow), .o_call_taken(taken), .o_stack_full(full));

    ////////////////////////////////////////////////////////////////////////
    // clocks: subsidiary clock free-running, phase unrelated
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        sub_clk = 1'b0;
        forever #17 sub_clk = ~sub_clk;
    end
    // hang guard, sized well above the longest divider run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            $display("FAIL t=%0t timeout", $time);
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checked %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data appears in the cycle after the strobe and holds until the next read
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic wait_wake(input int max, output int n);
        n = 0;
        while (wake !== 1'b1 && n < max) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    task automatic expect_call(input int exp);
        int n;
        n = 0;
        while (call_req !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({7'h0, call_req}, 8'h01);
        chk({5'h0, vec}, 8'(exp));
        while (call_req === 1'b1 && n < 80) begin
            @(posedge clk);
            #1;
            n++;
        end
        // the request must drop once the core takes the call
        chk({7'h0, call_req}, 8'h00);
    endtask
    task automatic no_call;
        int n;
        n = 0;
        repeat (20) begin
            @(posedge clk);
            #1;
            if (call_req !== 1'b0)
                n++;
        end
        chk(8'(n), 8'h00);
    endtask
    task automatic ret(input logic irq);
        @(posedge clk);
        ret_irq <= irq;
        ret_plain <= !irq;
        @(posedge clk);
        ret_irq <= 1'b0;
        ret_plain <= 1'b0;
    endtask
    // run a divider, time the flag's wake, check the flag, stop and clear
    task automatic tb_period(input logic [3:0] a, input logic [7:0] c,
        input int exp, input int tol, input logic [7:0] f);
        int n;
        wr_reg(a, c);
        wait_wake(exp + tol, n);
        chk(8'(n >= exp - tol && n <= exp + tol), 8'h01);
        rd_chk(itb_pkg::ADDR_IRQ_FLAGS, f);
        wr_reg(a, 8'h00);
        wr_reg(itb_pkg::ADDR_IRQ_FLAGS, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, wr, rd, lv, nvm, ser, ret_irq, ret_plain, slow} = '0;
        addr = 4'h0;
        wdata = 8'h00;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 6; a++) rd_chk(4'(a), 8'h00);
        wr_reg(4'hf, 8'hff);
        rd_chk(4'hf, 8'h00);
        wr_reg(itb_pkg::ADDR_PSC, 8'hff);
        rd_chk(itb_pkg::ADDR_PSC, 8'h03);
        wr_reg(itb_pkg::ADDR_TB0, 8'h7f);
        rd_chk(itb_pkg::ADDR_TB0, 8'h07);
        wait_wake(300, k);
        chk(8'(k == 300), 8'h01);
        $display("test registers done");
        wr_reg(itb_pkg::ADDR_PSC, 8'h00);
        tb_period(itb_pkg::ADDR_TB0, 8'h80, 256, 6, 8'h10);
        wr_reg(itb_pkg::ADDR_PSC, 8'h01);
        tb_period(itb_pkg::ADDR_TB0, 8'h80, 1024, 8, 8'h10);
        wr_reg(itb_pkg::ADDR_PSC, 8'h02);
        tb_period(itb_pkg::ADDR_TB0, 8'h80, 2176, 24, 8'h10);
        wr_reg(itb_pkg::ADDR_PSC, 8'h03);
        tb_period(itb_pkg::ADDR_TB1, 8'h81, 4352, 30, 8'h20);
        wr_reg(itb_pkg::ADDR_PSC, 8'h00);
        tb_period(itb_pkg::ADDR_TB1, 8'h87, 32768, 6, 8'h20);
        $display("test time bases done");
        slow <= 1'b1;
        wr_reg(itb_pkg::ADDR_IRQ_ENABLES, 8'h01);
        wr_reg(itb_pkg::ADDR_CORE_CTRL, 8'h01);
        lv <= 1'b1;
        wait_wake(20, k);
        chk(8'(k < 20), 8'h01);
        expect_call(itb_pkg::SRC_LV);
        rd_chk(itb_pkg::ADDR_IRQ_ENABLES, 8'h01);
        rd_chk(itb_pkg::ADDR_CORE_CTRL, 8'h00);
        ret(1'b0);
        rd_chk(itb_pkg::ADDR_CORE_CTRL, 8'h00);
        $display("test low voltage done");
        wr_reg(itb_pkg::ADDR_IRQ_ENABLES, 8'h00);
        wr_reg(itb_pkg::ADDR_CORE_CTRL, 8'h01);
        nvm <= 1'b1;
        wait_wake(20, k);
        chk(8'(k < 20), 8'h01);
        no_call();
        rd_chk(itb_pkg::ADDR_IRQ_ENABLES, 8'h20);
        @(posedge clk);
        nvm <= 1'b0;
        repeat (8) @(posedge clk);
        nvm <= 1'b1;
        wait_wake(20, k);
        chk(8'(k == 20 && wake === 1'b0), 8'h01);
        wr_reg(itb_pkg::ADDR_IRQ_ENABLES, 8'h22);
        expect_call(itb_pkg::SRC_NVM);
        rd_chk(itb_pkg::ADDR_IRQ_ENABLES, 8'h02);
        ret(1'b1);
        rd_chk(itb_pkg::ADDR_CORE_CTRL, 8'h01);
        $display("test nvm done");
        slow <= 1'b0;
        wr_reg(itb_pkg::ADDR_IRQ_FLAGS, 8'h37);
        expect_call(itb_pkg::SRC_TB0);
        rd_chk(itb_pkg::ADDR_IRQ_FLAGS, 8'h27);
        wr_reg(itb_pkg::ADDR_CORE_CTRL, 8'h01);
        expect_call(itb_pkg::SRC_TB1);
        wr_reg(itb_pkg::ADDR_CORE_CTRL, 8'h01);
        ser <= 1'b1;
        wait_wake(20, k);
        chk(8'(k < 20), 8'h01);
        no_call();
        rd_chk(itb_pkg::ADDR_IRQ_FLAGS, 8'h47);
        ret(1'b1);
        expect_call(itb_pkg::SRC_SERIAL);
        rd_chk(itb_pkg::ADDR_IRQ_FLAGS, 8'h07);
        ret(1'b1);
        ret(1'b1);
        $display("test priority done");
        complete_run();
    end
endmodule
